// >>> shared/utx_cfg.svh
`ifndef UTX_CFG_SVH
`define UTX_CFG_SVH
`define UTX_FIFO_DEPTH 16
`define UTX_FIFO_AW 4
`define UTX_DATA_W 8
`define UTX_DIV_W 16
`define UTX_OVS_LAST 4'hf
`define UTX_OVS_HALF 4'h7
`define UTX_LCR_WLS 1:0
`define UTX_LCR_STB 2
`define UTX_LCR_PEN 3
`define UTX_LCR_EPS 4
`define UTX_LCR_STICK 5
`define UTX_LCR_BRK 6
`define UTX_FCR_TRIG 7:6
`define UTX_DIV_ONE 16'h0001
`define UTX_WLS_BASE 3'h4
`define UTX_TRIG_0 5'h00
`define UTX_TRIG_1 5'h01
`define UTX_TRIG_2 5'h04
`define UTX_TRIG_3 5'h08
`endif

// >>> shared/utx_pkg.sv
package utx_pkg;
	typedef enum logic [2:0] {UTX_IDLE, UTX_START, UTX_DATA, UTX_PAR, UTX_STOP} utx_state_t;
	typedef logic [7:0] utx_byte_t;
endpackage

// >>> logic/utx_fifo.sv
`include "utx_cfg.svh"
module utx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] rd, wr, next_rd, next_wr;
	logic [AW:0] cnt, next_cnt;
	logic push, pop;

	assign in_ready = (cnt != (AW+1)'(DEPTH));
	assign out_valid = (cnt != '0);
	assign out_data = mem[rd];
	assign level = cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		next_rd = rd;
		next_wr = wr;
		next_cnt = cnt;
		if (flush)
		begin
			next_rd = '0;
			next_wr = '0;
			next_cnt = '0;
		end
		else
		begin
			if (push)
				next_wr = wr + 1'b1;
			if (pop)
				next_rd = rd + 1'b1;
			next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rd <= '0;
			wr <= '0;
			cnt <= '0;
		end
		else
		begin
			rd <= next_rd;
			wr <= next_wr;
			cnt <= next_cnt;
		end
		if (push)
			mem[wr] <= in_data;
	end
endmodule

// >>> logic/utx_transmit.sv
`include "utx_cfg.svh"
module utx_transmit
	import utx_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Host character write
	input wire utx_pkg::utx_byte_t WR_DATA,
	input wire logic WR_VALID,
	output logic WR_READY,
	// Configuration
	input wire utx_pkg::utx_byte_t LINE_CTRL,
	input wire utx_pkg::utx_byte_t FIFO_CTRL,
	input wire logic [`UTX_DIV_W-1:0] DIVISOR,
	input wire logic HOLD_EMPTY_IE,
	// Serial side and status
	output logic BAUD_TICK_OUT,
	output logic SERIAL_LINE_OUT,
	output logic TX_HOLDING_EMPTY,
	output logic TX_EMPTY,
	output logic TX_IRQ
);
	// ****************************************
	// Baud generator
	// ****************************************
	logic [`UTX_DIV_W-1:0] baud_cnt, next_baud_cnt;
	logic tick, next_tick;
	logic [`UTX_DIV_W-1:0] div_safe;

	assign div_safe = (DIVISOR == '0) ? `UTX_DIV_ONE : DIVISOR;

	// One tick per divisor period, sixteen per bit
	always_comb
	begin
		next_tick = 1'b0;
		next_baud_cnt = baud_cnt + `UTX_DIV_ONE;
		if (baud_cnt >= div_safe - `UTX_DIV_ONE)
		begin
			next_baud_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			baud_cnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			baud_cnt <= next_baud_cnt;
			tick <= next_tick;
		end
	end

	assign BAUD_TICK_OUT = tick;

	// ****************************************
	// Holding store
	// ****************************************
	logic fifo_mode;
	logic hs_valid, hs_pop;
	utx_byte_t hs_data;
	logic [`UTX_FIFO_AW:0] hs_level;

	// Character mode uses only one entry, like a single holding register
	assign fifo_mode = FIFO_CTRL[0];

	logic wr_ok;
	assign wr_ok = fifo_mode ? 1'b1 : (hs_level == '0);

	logic fifo_in_ready;
	assign WR_READY = fifo_in_ready && wr_ok;

	// Flush is a level; a character already in the shifter still goes out
	utx_fifo #(.WIDTH(`UTX_DATA_W), .DEPTH(`UTX_FIFO_DEPTH), .AW(`UTX_FIFO_AW)) u_store (
		.clk(CLK),
		.reset(RESET),
		.flush(FIFO_CTRL[2]),
		.in_valid(WR_VALID && wr_ok),
		.in_ready(fifo_in_ready),
		.in_data(WR_DATA),
		.out_valid(hs_valid),
		.out_ready(hs_pop),
		.out_data(hs_data),
		.level(hs_level)
	);

	// ****************************************
	// Shift register and framing
	// ****************************************
	utx_state_t state, next_state;
	utx_byte_t tx_shift_reg, next_shift;
	logic [3:0] ovs, next_ovs;
	logic [2:0] bit_idx, next_bit_idx;
	logic [1:0] stop_idx, next_stop_idx;
	logic par, next_par;
	logic serial_line_out, next_serial_line_out;
	logic [2:0] last_bit;
	logic [1:0] stop_last;
	logic half_stop;

	// Format from line control
	// Index of the last data bit: 4 for 5-bit words up to 7
	assign last_bit = `UTX_WLS_BASE + {1'b0, LINE_CTRL[`UTX_LCR_WLS]};
	assign half_stop = LINE_CTRL[`UTX_LCR_STB] && (LINE_CTRL[`UTX_LCR_WLS] == 2'b00);
	assign stop_last = LINE_CTRL[`UTX_LCR_STB] ? 2'b01 : 2'b00;

	// Pop only when shifter idle
	assign hs_pop = (state == UTX_IDLE) && tick;

	always_comb
	begin
		next_state = state;
		next_shift = tx_shift_reg;
		next_ovs = ovs;
		next_bit_idx = bit_idx;
		next_stop_idx = stop_idx;
		next_par = par;
		next_serial_line_out = serial_line_out;
		// All bit timing advances only on the baud tick
		if (tick)
		begin
			unique case (state)
				UTX_IDLE:
				begin
					next_serial_line_out = 1'b1;
					if (hs_valid)
					begin
						next_shift = hs_data;
						next_par = ~LINE_CTRL[`UTX_LCR_EPS];
						next_state = UTX_START;
						next_ovs = '0;
						next_serial_line_out = 1'b0;
					end
				end
				UTX_START:
				begin
					next_ovs = ovs + 4'h1;
					if (ovs == `UTX_OVS_LAST)
					begin
						next_state = UTX_DATA;
						next_bit_idx = '0;
						next_serial_line_out = tx_shift_reg[0];
					end
				end
				UTX_DATA:
				begin
					next_ovs = ovs + 4'h1;
					if (ovs == `UTX_OVS_LAST)
					begin
						// LSB first; parity folded as bits leave
						next_par = par ^ tx_shift_reg[0];
						next_shift = {1'b0, tx_shift_reg[7:1]};
						next_bit_idx = bit_idx + 3'h1;
						next_serial_line_out = tx_shift_reg[1];
						if (bit_idx == last_bit)
						begin
							next_stop_idx = '0;
							if (LINE_CTRL[`UTX_LCR_PEN])
							begin
								next_state = UTX_PAR;
								next_serial_line_out = LINE_CTRL[`UTX_LCR_STICK] ? ~LINE_CTRL[`UTX_LCR_EPS]
									: par ^ tx_shift_reg[0];
							end
							else
							begin
								next_state = UTX_STOP;
								next_serial_line_out = 1'b1;
							end
						end
					end
				end
				UTX_PAR:
				begin
					next_ovs = ovs + 4'h1;
					if (ovs == `UTX_OVS_LAST)
					begin
						next_state = UTX_STOP;
						next_stop_idx = '0;
						next_serial_line_out = 1'b1;
					end
				end
				UTX_STOP:
				begin
					next_ovs = ovs + 4'h1;
					next_serial_line_out = 1'b1;
					// Half stop bit ends at mid count for 5-bit words
					if ((half_stop && stop_idx == 2'b01 && ovs == `UTX_OVS_HALF) || ovs == `UTX_OVS_LAST)
					begin
						next_ovs = '0;
						next_stop_idx = stop_idx + 2'b01;
						if (stop_idx == stop_last)
							next_state = UTX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			state <= UTX_IDLE;
			tx_shift_reg <= '0;
			ovs <= '0;
			bit_idx <= '0;
			stop_idx <= '0;
			par <= 1'b0;
			serial_line_out <= 1'b1;
		end
		else
		begin
			state <= next_state;
			tx_shift_reg <= next_shift;
			ovs <= next_ovs;
			bit_idx <= next_bit_idx;
			stop_idx <= next_stop_idx;
			par <= next_par;
			serial_line_out <= next_serial_line_out;
		end
	end

	// Break forces space without disturbing the shifter
	assign SERIAL_LINE_OUT = serial_line_out & ~LINE_CTRL[`UTX_LCR_BRK];

	// ****************************************
	// Holding-empty interrupt
	// ****************************************
	logic irq, next_irq;
	logic [`UTX_FIFO_AW:0] trig;

	// Low-water mark from FIFO control bits 7:6: 0, 1, 4, 8 left
	always_comb
	begin
		unique case (FIFO_CTRL[`UTX_FCR_TRIG])
			2'b00: trig = `UTX_TRIG_0;
			2'b01: trig = `UTX_TRIG_1;
			2'b10: trig = `UTX_TRIG_2;
			2'b11: trig = `UTX_TRIG_3;
		endcase
	end

	always_comb
	begin
		if (fifo_mode)
			next_irq = HOLD_EMPTY_IE && (hs_level <= trig);
		else
			next_irq = HOLD_EMPTY_IE && (hs_level == '0) && !(WR_VALID && WR_READY);
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			irq <= 1'b0;
		else
			irq <= next_irq;
	end

	assign TX_IRQ = irq;
	assign TX_HOLDING_EMPTY = (hs_level == '0);
	assign TX_EMPTY = (hs_level == '0) && (state == UTX_IDLE);

	// ****************************************
	// Checks
	// ****************************************
	a_idle_mark: assert property (@(posedge CLK) disable iff (RESET)
		(state == UTX_IDLE && $past(state) == UTX_IDLE && !LINE_CTRL[`UTX_LCR_BRK]) |-> SERIAL_LINE_OUT)
		else $error("line not at mark while idle");
	a_load_idle: assert property (@(posedge CLK) disable iff (RESET)
		(state != UTX_IDLE && !FIFO_CTRL[2]) |=> hs_level >= $past(hs_level))
		else $error("shifter loaded while busy");
	a_start_low: assert property (@(posedge CLK) disable iff (RESET)
		(state == UTX_IDLE && tick && hs_valid) |=> (state == UTX_START && serial_line_out == 1'b0))
		else $error("start bit missing");
	a_tick_only: assert property (@(posedge CLK) disable iff (RESET)
		!tick |=> $stable(state))
		else $error("state moved without tick");
	a_irq_clear: assert property (@(posedge CLK) disable iff (RESET)
		(!fifo_mode && WR_VALID && WR_READY) |=> !TX_IRQ)
		else $error("interrupt not cleared by write");
	a_irq_set: assert property (@(posedge CLK) disable iff (RESET)
		(!fifo_mode && $stable(FIFO_CTRL) && HOLD_EMPTY_IE && hs_level == '0 && !WR_VALID) |=> TX_IRQ)
		else $error("holding-empty interrupt missing");
	a_fifo_irq: assert property (@(posedge CLK) disable iff (RESET)
		(fifo_mode && HOLD_EMPTY_IE && hs_level > trig) |=> !TX_IRQ)
		else $error("fifo interrupt above trigger");
	a_fifo_cap: assert property (@(posedge CLK) disable iff (RESET)
		hs_level == 5'h10 |-> !WR_READY)
		else $error("write accepted when full");
	a_tick_rate: assert property (@(posedge CLK) disable iff (RESET)
		(tick && DIVISOR == 16'h0002 && $stable(DIVISOR)) |=> !tick ##1 tick)
		else $error("baud tick spacing wrong");
	a_stop_mark: assert property (@(posedge CLK) disable iff (RESET)
		(state == UTX_STOP && !LINE_CTRL[`UTX_LCR_BRK]) |-> SERIAL_LINE_OUT)
		else $error("stop bit not mark");
endmodule

// >>> dv/utx_far_rx.sv
module utx_far_rx
	import utx_pkg::*;
(
	// Line side
	input wire logic clk,
	input wire logic tick,
	input wire logic line,
	input wire utx_pkg::utx_byte_t fmt,
	// Result
	output utx_pkg::utx_byte_t rx_data,
	output logic rx_ok,
	output logic [7:0] rx_count
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	logic p;
	// ********************
	// Mid-bit sampler
	// ********************
	// Negedge sampling keeps clear of the tick register update
	task automatic ticks(input int k);
		repeat (k)
		begin
			do @(negedge clk); while (!tick);
		end
	endtask
	initial
	begin
		rx_count = 8'h00;
		rx_data = 8'h00;
		rx_ok = 1'b0;
		forever
		begin
			@(negedge line);
			ticks(8);
			// A short break pulse is a false start, not a frame
			if (line)
				continue;
			rx_ok = !line;
			rx_data = 8'h00;
			p = !fmt[4];
			for (n = 0; n < 5 + fmt[1:0]; n++)
			begin
				ticks(16);
				rx_data[n] = line;
				p = p ^ line;
			end
			if (fmt[3])
			begin
				ticks(16);
				rx_ok = rx_ok & (line === (fmt[5] ? !fmt[4] : p));
			end
			ticks(16);
			rx_ok = rx_ok & (line === 1'b1);
			rx_count = rx_count + 8'h01;
		end
	end
endmodule

// >>> dv/testbench.sv
`include "utx_cfg.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import utx_pkg::*;
	logic clk = 1'b0, reset = 1'b1, wr_valid = 1'b0, ie = 1'b0;
	utx_byte_t wr_data = 8'h00, line_ctrl = 8'h03, fifo_ctrl = 8'h00, b, rx_data;
	logic [`UTX_DIV_W-1:0] divisor = 16'h0002;
	logic wr_ready, tick, serial_line_out, hold_empty, tx_empty, irq, rx_ok;
	logic [7:0] rx_count;
	int err_count = 0, tests_run = 0, acc, g, i;
	logic [31:0] seed = 32'h00691b0c;
	utx_byte_t exp_q[$];
	utx_transmit u_dut (.CLK(clk), .RESET(reset), .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.LINE_CTRL(line_ctrl), .FIFO_CTRL(fifo_ctrl), .DIVISOR(divisor), .HOLD_EMPTY_IE(ie),
		.BAUD_TICK_OUT(tick), .SERIAL_LINE_OUT(serial_line_out), .TX_HOLDING_EMPTY(hold_empty), .TX_EMPTY(tx_empty), .TX_IRQ(irq));
	utx_far_rx u_far (.clk(clk), .tick(tick), .line(serial_line_out), .fmt(line_ctrl), .rx_data(rx_data), .rx_ok(rx_ok),
		.rx_count(rx_count));
	always #20 clk = ~clk;
	// ********************
	// Helpers
	// ********************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic rnd();
		seed = xorshift(seed);
		b = seed[7:0];
	endtask
	function automatic utx_byte_t msk(input utx_byte_t v);
		return v & utx_byte_t'((9'h001 << (5 + line_ctrl[1:0])) - 9'h001);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic send(input utx_byte_t v);
		@(negedge clk);
		wr_data = v;
		wr_valid = 1'b1;
		for (int k = 0; k < 9000 && !wr_ready; k++) @(negedge clk);
		exp_q.push_back(msk(v));
		@(negedge clk);
		wr_valid = 1'b0;
	endtask
	task automatic drain();
		for (int k = 0; k < 9000 && !tx_empty; k++) @(negedge clk);
		repeat (400) @(negedge clk);
		check(exp_q.size(), 0);
	endtask
	// Cheap gap count; the tick is a one-cycle pulse
	task automatic gap(output int n);
		do @(negedge clk); while (!tick);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (!tick);
	endtask
	always @(rx_count)
		if (!reset)
		begin
			check(exp_q.size() > 0, 1);
			if (exp_q.size() > 0) check(rx_data, exp_q.pop_front());
			check(rx_ok, 1'b1);
		end
	initial
	begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_of_test();
	end
	// ********************
	// Scenarios
	// ********************
	initial
	begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		check({serial_line_out, tx_empty, irq, wr_ready}, 4'hd);
		for (i = 1; i <= 3; i++)
		begin
			divisor = 16'(i);
			gap(g);
			gap(g);
			check(g, i);
		end
		divisor = 16'h0002;
		ie = 1'b1;
		repeat (2) @(negedge clk);
		check(irq, 1'b1);
		rnd();
		send(b);
		check(irq, 1'b0);
		drain();
		check(irq, 1'b1);
		line_ctrl = 8'h43;
		@(negedge clk);
		check(serial_line_out, 1'b0);
		line_ctrl = 8'h03;
		repeat (40) @(negedge clk);
		check(serial_line_out, 1'b1);
		for (i = 0; i < 16; i++)
		begin
			rnd();
			line_ctrl = {2'b00, b[1], b[0], i[3:0]};
			repeat (2)
			begin
				rnd();
				send(b);
			end
			drain();
		end
		line_ctrl = 8'h03;
		fifo_ctrl = 8'hc1;
		acc = 0;
		wr_valid = 1'b1;
		rnd();
		wr_data = b;
		// Data only moves on after the store took it
		repeat (30)
		begin
			g = wr_ready;
			if (g)
			begin
				exp_q.push_back(wr_data);
				acc++;
			end
			@(negedge clk);
			if (g)
			begin
				rnd();
				wr_data = b;
			end
		end
		wr_valid = 1'b0;
		check(acc, 17);
		check({irq, hold_empty}, 2'b00);
		drain();
		check(irq, 1'b1);
		ie = 1'b0;
		repeat (2) @(negedge clk);
		check(irq, 1'b0);
		// Flush: only the character in the shifter survives
		ie = 1'b1;
		fifo_ctrl = 8'h81;
		wr_valid = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			rnd();
			wr_data = b;
			if (i == 0)
				exp_q.push_back(b);
			@(negedge clk);
		end
		wr_valid = 1'b0;
		check({irq, hold_empty}, 2'b00);
		fifo_ctrl = 8'h85;
		@(negedge clk);
		fifo_ctrl = 8'h81;
		check(hold_empty, 1'b1);
		@(negedge clk);
		check(irq, 1'b1);
		drain();
		end_of_test();
	end
endmodule
